// ---- design/ssr_receiver.sv ----
`timescale 1ns/1ns
// Contract
// - single receive alone: master makes exactly one character of clock cycles
// - single receive bit clears itself after one complete character
// - continuous receive: master clocks without pause until software clears it or overrun sets
// - continuous cleared mid character: clock stops at once, partial character dropped
// - both set: single clears after first character, continuous carries on
// - data pin sampled on trailing clock edge, shifted into shift register
// - complete character raises receive flag and enters two-entry FIFO
// - receive data register shows low eight bits of oldest character
// - receive flag stays set while any unread character remains
// - slave mode takes clock from pin, one bit per cycle
// - third character into full FIFO sets overrun, stored data kept
// - during overrun FIFO readable, no new characters accepted
// - overrun in single mode cleared by reading receive data
// - overrun in continuous mode cleared by clearing continuous or port enable
// - nine-bit mode shifts nine bits, ninth bit of oldest shown in status
// - completed character with interrupt enable raises interrupt request
// - master clock rate from 16-bit divisor, high-speed and wide select
// - receive flag read-only, follows FIFO occupancy only
module ssr_receiver
  import ssr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic DATA_PIN_I,
  input wire logic CLOCK_PIN_I,
  output logic CLOCK_PIN_O,
  output logic CLOCK_PIN_OE,
  output logic RECEIVE_IRQ
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] baud_control;
  logic [7:0] rx_ctrl;
  logic [7:0] rate_divisor_low;
  logic [7:0] rate_divisor_high;
  logic [7:0] transmit_data;
  logic [7:0] tx_ctrl;
  logic receive_interrupt_enable;
  logic overrun_flag;
  logic overrun_single;
  logic [8:0] fifo_mem [FIFO_DEPTH];
  logic rd_ptr;
  logic wr_ptr;
  logic [1:0] fifo_count;
  logic [8:0] shift_reg;
  logic [3:0] bit_count;
  logic [15:0] div_count;
  logic [1:0] prescale;
  ssr_state_type state;
  logic data_s1, data_s2, clk_s1, clk_s2, clk_s3;
  logic wr_en, rd_en, data_read, fifo_full, char_done, trail_edge;
  logic port_enable, single_rx, cont_rx, nine_bits, master, rx_on;
  logic [3:0] char_bits;
  logic [15:0] divisor;
  logic [1:0] prescale_max;
  logic baud_tick;
  assign port_enable = rx_ctrl[BIT_PORT_ENABLE];
  assign single_rx = rx_ctrl[BIT_SINGLE_RX];
  assign cont_rx = rx_ctrl[BIT_CONT_RX];
  assign nine_bits = rx_ctrl[BIT_NINTH_ENABLE];
  assign master = tx_ctrl[BIT_CLOCK_MASTER];
  assign rx_on = port_enable && (single_rx || cont_rx) && !overrun_flag;
  assign char_bits = nine_bits ? BITS_WIDE : BITS_NARROW;
  assign fifo_full = (fifo_count == 2'(FIFO_DEPTH));
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;
  assign data_read = rd_en && (PADDR == OFS_RECEIVE_DATA);
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      data_s1 <= 1'b0;
      data_s2 <= 1'b0;
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
    end else begin
      data_s1 <= DATA_PIN_I;
      data_s2 <= data_s1;
      clk_s1 <= CLOCK_PIN_I;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
    end
  end
  // ---------------------------------------------------------------
  // rate generator
  // ---------------------------------------------------------------
  // wide select uses all 16 bits; high speed shortens prescale to 1
  always_comb begin
    divisor = baud_control[BIT_WIDE_DIVISOR] ? {rate_divisor_high, rate_divisor_low}
                                             : {8'h00, rate_divisor_low};
    prescale_max = tx_ctrl[BIT_HIGH_SPEED] ? 2'h0 : 2'h3;
  end
  assign baud_tick = (div_count == 16'h0000) && (prescale == 2'h0);
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_count <= 16'h0000;
      prescale <= 2'h0;
    end else if (state == SSR_IDLE) begin
      div_count <= 16'h0000;
      prescale <= 2'h0;
    end else if (div_count == 16'h0000) begin
      div_count <= divisor;
      prescale <= (prescale == 2'h0) ? prescale_max : prescale - 2'h1;
    end else begin
      div_count <= div_count - 16'h0001;
    end
  end
  // ---------------------------------------------------------------
  // shift clock and shift register
  // ---------------------------------------------------------------
  // slave trailing edge is the falling edge seen after synchronising
  assign trail_edge = master ? (state == SSR_HIGH && baud_tick)
                             : (clk_s3 && !clk_s2);
  assign char_done = rx_on && trail_edge && (bit_count == char_bits - 4'h1);
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= SSR_IDLE;
    end else if (!rx_on || !master) begin
      state <= SSR_IDLE;
    end else begin
      case (state)
        SSR_IDLE: state <= SSR_LOW;
        SSR_LOW: if (baud_tick) state <= SSR_HIGH;
        SSR_HIGH: begin
          if (baud_tick) begin
            // single alone stops after last bit continuous keeps going
            if (char_done && !cont_rx) state <= SSR_IDLE;
            else state <= SSR_LOW;
          end
        end
        default: state <= SSR_IDLE;
      endcase
    end
  end
  assign CLOCK_PIN_OE = port_enable && master;
  assign CLOCK_PIN_O = (state == SSR_HIGH);
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      shift_reg <= 9'h000;
      bit_count <= 4'h0;
    end else if (!rx_on) begin
      shift_reg <= 9'h000;
      bit_count <= 4'h0;
    end else if (trail_edge) begin
      shift_reg <= {data_s2, shift_reg[8:1]};
      bit_count <= char_done ? 4'h0 : bit_count + 4'h1;
    end
  end
  // ---------------------------------------------------------------
  // receive fifo
  // ---------------------------------------------------------------
  logic [8:0] new_char;
  assign new_char = nine_bits ? {data_s2, shift_reg[8:1]} : {1'b0, data_s2, shift_reg[8:2]};
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      fifo_count <= 2'h0;
      fifo_mem[0] <= 9'h000;
      fifo_mem[1] <= 9'h000;
    end else if (!port_enable) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      fifo_count <= 2'h0;
    end else begin
      if (char_done && !fifo_full) begin
        fifo_mem[wr_ptr] <= new_char;
        wr_ptr <= ~wr_ptr;
      end
      if (data_read && fifo_count != 2'h0) rd_ptr <= ~rd_ptr;
      fifo_count <= fifo_count + 2'(char_done && !fifo_full)
                    - 2'(data_read && fifo_count != 2'h0);
    end
  end
  // ---------------------------------------------------------------
  // overrun
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      overrun_flag <= 1'b0;
      overrun_single <= 1'b0;
    end else if (char_done && fifo_full) begin
      overrun_flag <= 1'b1;
      overrun_single <= !cont_rx;
    end else if (!port_enable) begin
      overrun_flag <= 1'b0;
    end else if (overrun_single && data_read) begin
      overrun_flag <= 1'b0;
    end else if (!overrun_single && !cont_rx) begin
      overrun_flag <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) RECEIVE_IRQ <= 1'b0;
    else RECEIVE_IRQ <= receive_interrupt_enable && (fifo_count != 2'h0);
  end
  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      baud_control <= RST_BYTE;
      rx_ctrl <= RST_BYTE;
      rate_divisor_low <= RST_BYTE;
      rate_divisor_high <= RST_BYTE;
      transmit_data <= RST_BYTE;
      tx_ctrl <= RST_BYTE;
      receive_interrupt_enable <= 1'b0;
    end else begin
      if (wr_en) begin
        case (PADDR)
          OFS_BAUD_CONTROL: baud_control <= PWDATA[7:0];
          OFS_RX_STATUS_CONTROL: rx_ctrl <= PWDATA[7:0];
          OFS_RATE_DIVISOR_LOW: rate_divisor_low <= PWDATA[7:0];
          OFS_RATE_DIVISOR_HIGH: rate_divisor_high <= PWDATA[7:0];
          OFS_TRANSMIT_DATA: transmit_data <= PWDATA[7:0];
          OFS_TX_STATUS_CONTROL: tx_ctrl <= PWDATA[7:0];
          OFS_INT_CONTROL: receive_interrupt_enable <= PWDATA[BIT_RX_INT_ENABLE];
          default: ;
        endcase
      end
      // hardware clear wins over a write landing in the same cycle
      if (char_done) begin
        rx_ctrl[BIT_SINGLE_RX] <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        OFS_BAUD_CONTROL: PRDATA <= {24'h000000, baud_control & 8'h1b};
        OFS_RX_STATUS_CONTROL: PRDATA <= {24'h000000, rx_ctrl[7:4], 2'b00,
                                          overrun_flag, fifo_mem[rd_ptr][8]};
        OFS_RATE_DIVISOR_LOW: PRDATA <= {24'h000000, rate_divisor_low};
        OFS_RATE_DIVISOR_HIGH: PRDATA <= {24'h000000, rate_divisor_high};
        OFS_TX_STATUS_CONTROL: PRDATA <= {24'h000000, tx_ctrl};
        OFS_RECEIVE_DATA: PRDATA <= {24'h000000, fifo_mem[rd_ptr][7:0]};
        OFS_INT_CONTROL: PRDATA <= {30'h00000000, fifo_count != 2'h0,
                                    receive_interrupt_enable};
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_FLAG_OCC: assert property (@(posedge CLK) disable iff (!RST_N)
    (fifo_count != 2'h0) |=> (RECEIVE_IRQ == $past(receive_interrupt_enable)))
    else $error("irq does not follow fifo");
  AST_SINGLE_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
    char_done |=> !rx_ctrl[BIT_SINGLE_RX]) else $error("single not cleared");
  AST_OVR_SET: assert property (@(posedge CLK) disable iff (!RST_N)
    (char_done && fifo_full && port_enable)
    |=> overrun_flag && fifo_count == ($past(data_read) ? 2'h1 : 2'h2))
    else $error("overrun not set");
  AST_OVR_BLOCK: assert property (@(posedge CLK) disable iff (!RST_N)
    overrun_flag |-> !char_done) else $error("char during overrun");
  AST_ABORT: assert property (@(posedge CLK) disable iff (!RST_N)
    ($fell(cont_rx) && !single_rx) |=> state == SSR_IDLE && bit_count == 4'h0)
    else $error("abort not immediate");
  AST_CLK_IDLE: assert property (@(posedge CLK) disable iff (!RST_N)
    !rx_on |=> !CLOCK_PIN_O) else $error("clock runs while idle");
  AST_PE_RESET: assert property (@(posedge CLK) disable iff (!RST_N)
    !port_enable |=> fifo_count == 2'h0 && !overrun_flag) else $error("no port reset");
  AST_OVR_READ: assert property (@(posedge CLK) disable iff (!RST_N)
    (overrun_flag && overrun_single && data_read && port_enable && !char_done)
    |=> !overrun_flag) else $error("overrun not cleared by read");
  // ---------------------------------------------------------------
  // checks on fifo and flow
  // ---------------------------------------------------------------
  // two entries only; a third slot would hide overrun
  AST_FIFO_BOUND: assert property (@(posedge CLK) disable iff (!RST_N)
    fifo_count <= 2'h2)
    else $error("fifo count beyond two");
  // a finished character must land when there is room
  AST_CHAR_STORED: assert property (@(posedge CLK) disable iff (!RST_N)
    (char_done && !fifo_full && port_enable && !data_read)
    |=> fifo_count == $past(fifo_count) + 2'h1) else $error("character not stored");
  // request follows the enable two edges on
  AST_IRQ_RISE: assert property (@(posedge CLK) disable iff (!RST_N)
    (char_done && receive_interrupt_enable)
    |=> ##1 (RECEIVE_IRQ == $past(receive_interrupt_enable))) else $error("no irq");
  // stored data frozen while overrun blocks the receiver
  AST_OVR_KEEP: assert property (@(posedge CLK) disable iff (!RST_N)
    overrun_flag |=> $stable(fifo_mem[0]) && $stable(fifo_mem[1]))
    else $error("fifo changed in overrun");
  // continuous overrun goes once continuous is low
  AST_CONT_CLR: assert property (@(posedge CLK) disable iff (!RST_N)
    (overrun_flag && !overrun_single && !cont_rx) |=> !overrun_flag)
    else $error("overrun not cleared by continuous");
  // no partial character survives a stop
  AST_SHIFT_IDLE: assert property (@(posedge CLK) disable iff (!RST_N)
    !rx_on |=> bit_count == 4'h0 && shift_reg == 9'h000)
    else $error("partial character kept");
  // slave never drives a clock of its own
  AST_NO_CLK_SLAVE: assert property (@(posedge CLK) disable iff (!RST_N)
    !master |=> !CLOCK_PIN_O)
    else $error("clock driven in slave mode");
  // single alone: clock stops after the last bit
  AST_ONE_SHOT: assert property (@(posedge CLK) disable iff (!RST_N)
    (char_done && !cont_rx) |=> state == SSR_IDLE)
    else $error("clock runs past one character");
  // a data read moves to the next character
  AST_READ_POP: assert property (@(posedge CLK) disable iff (!RST_N)
    (data_read && fifo_count != 2'h0 && port_enable) |=> rd_ptr != $past(rd_ptr))
    else $error("read did not advance fifo");
  // flag can only rise with a new character
  AST_EMPTY_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
    (fifo_count == 2'h0 && !char_done) |=> fifo_count == 2'h0)
    else $error("flag set without character");
  // one bit per trailing edge
  AST_BIT_COUNT: assert property (@(posedge CLK) disable iff (!RST_N)
    (rx_on && trail_edge && !char_done) |=> bit_count == $past(bit_count) + 4'h1)
    else $error("bit not counted");
  // both set: continuous survives the first character
  AST_SINGLE_TO_CONT: assert property (@(posedge CLK) disable iff (!RST_N)
    (char_done && single_rx && cont_rx && !wr_en) |=> cont_rx && !single_rx)
    else $error("continuous lost after first character");
endmodule : ssr_receiver

// ---- design/ssr_pkg.sv ----
package ssr_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_BAUD_CONTROL = 8'h00;
  localparam logic [7:0] OFS_RX_STATUS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_RATE_DIVISOR_LOW = 8'h08;
  localparam logic [7:0] OFS_RATE_DIVISOR_HIGH = 8'h0c;
  localparam logic [7:0] OFS_TRANSMIT_DATA = 8'h10;
  localparam logic [7:0] OFS_TX_STATUS_CONTROL = 8'h14;
  localparam logic [7:0] OFS_RECEIVE_DATA = 8'h18;
  localparam logic [7:0] OFS_INT_CONTROL = 8'h1c;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_PORT_ENABLE = 7;
  localparam int BIT_NINTH_ENABLE = 6;
  localparam int BIT_SINGLE_RX = 5;
  localparam int BIT_CONT_RX = 4;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_NINTH_BIT = 0;
  localparam int BIT_WIDE_DIVISOR = 3;
  localparam int BIT_CLOCK_MASTER = 7;
  localparam int BIT_SYNC_MODE = 4;
  localparam int BIT_HIGH_SPEED = 2;
  localparam int BIT_RX_FLAG = 1;
  localparam int BIT_RX_INT_ENABLE = 0;
  // ---------------------------------------------------------------
  // reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int FIFO_DEPTH = 2;
  localparam logic [3:0] BITS_NARROW = 4'h8;
  localparam logic [3:0] BITS_WIDE = 4'h9;
  typedef enum logic [2:0] {
    SSR_IDLE = 3'b001,
    SSR_LOW = 3'b010,
    SSR_HIGH = 3'b100
  } ssr_state_type;
endpackage : ssr_pkg

// ---- bench/ssr_partner.sv ----
`timescale 1ns/1ns
// ---------------------------------------------------------------
// far-side serial device
// ---------------------------------------------------------------
module ssr_partner (
  input wire logic clk,
  input wire logic clock_pin_o,
  input wire logic clock_pin_oe,
  input wire logic [8:0] char_in,
  input wire logic [3:0] nbits,
  output logic data_pin,
  output logic clock_line
);
  logic slave_clk = 1'b0;
  logic busy = 1'b0;
  logic [8:0] word = 9'h000;
  int idx = 0;
  int idle = 0;
  initial data_pin = 1'b0;
  // receiver owns the clock pin only as clock master
  assign clock_line = clock_pin_oe ? clock_pin_o : slave_clk;
  // leading edge: next bit, lsb first, one bit per cycle
  always @(posedge clock_pin_o) begin
    if (clock_pin_oe) begin
      word = (idx == 0) ? char_in : word;
      data_pin <= word[idx];
      idx = (idx + 1 == int'(nbits)) ? 0 : idx + 1;
    end
  end
  // long idle ends a frame; line wanders so no stale bit can pass
  always @(posedge clk) begin
    idle = clock_line ? 0 : idle + 1;
    if (idle > 20 && !busy) begin
      idx = 0;
      data_pin <= ~data_pin;
    end
  end
  task automatic slave_send(input logic [8:0] v, input int n);
    busy = 1'b1;
    for (int i = 0; i < n; i++) begin // one clock per data bit
      @(posedge clk);
      data_pin <= v[i];
      slave_clk <= 1'b1;
      repeat (5) @(posedge clk);
      slave_clk <= 1'b0;
      repeat (5) @(posedge clk);
    end
    busy = 1'b0;
  endtask : slave_send
endmodule : ssr_partner

// ---- bench/sync_serial_receiver_test.sv ----
`timescale 1ns/1ns
// ---------------------------------------------------------------
// bench top
// ---------------------------------------------------------------
module sync_serial_receiver_test
  import ssr_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, ck_o, ck_oe, data_pin, ck_line;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [8:0] char_in;
  logic [3:0] nbits;
  int n_mismatch = 0, check_count = 0, edges = 0, cycles = 0;
  time t_prev = 0, t_last = 0;
  localparam logic [7:0] RX = OFS_RX_STATUS_CONTROL;
  ssr_receiver dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DATA_PIN_I(data_pin), .CLOCK_PIN_I(ck_line), .CLOCK_PIN_O(ck_o),
    .CLOCK_PIN_OE(ck_oe), .RECEIVE_IRQ(irq));
  ssr_partner u_partner (.clk(clk), .clock_pin_o(ck_o), .clock_pin_oe(ck_oe),
    .char_in(char_in), .nbits(nbits), .data_pin(data_pin), .clock_line(ck_line));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge ck_o) begin
    edges++;
    t_prev = t_last;
    t_last = $time;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
      output logic [31:0] rd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask : wr
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] v;
    apb(1'b0, a, 8'h00, v);
    check(v, exp, msg);
  endtask : expect_reg
  // polls status; a slow receiver only costs reads, the timeout guards a hang
  task automatic wait_bit(input int b, input logic val);
    logic [31:0] v;
    do begin
      apb(1'b0, RX, 8'h00, v);
    end while (v[b] !== val);
  endtask : wait_bit
  task automatic master_setup;
    wr(OFS_RATE_DIVISOR_LOW, 8'h03);
    wr(OFS_RATE_DIVISOR_HIGH, 8'h00);
    wr(OFS_TX_STATUS_CONTROL, 8'h94);
    wr(OFS_INT_CONTROL, 8'h01);
    wr(RX, 8'h80);
    edges = 0;
  endtask : master_setup
  task automatic test_reset;
    expect_reg(RX, 32'h0, "status reset");
    wr(OFS_INT_CONTROL, 8'h02);
    expect_reg(OFS_INT_CONTROL, 32'h0, "flag read only");
    wr(8'h20, 8'hff);
    expect_reg(8'h20, 32'h0, "unmapped");
    check(ck_oe, 1'b0, "clock idle");
    check(pslverr, 1'b0, "no bus error");
    check(pready, 1'b1, "bus ready");
    $display("test reset done");
  endtask : test_reset
  task automatic test_single;
    master_setup();
    char_in <= 9'h0a5;
    wr(RX, 8'ha0);
    wait_bit(BIT_SINGLE_RX, 1'b0);
    repeat (40) @(posedge clk);
    check(edges, 8, "clock count");
    check(32'(t_last - t_prev), 32'd160, "clock period");
    check(irq, 1'b1, "irq");
    expect_reg(RX, 32'h80, "single cleared");
    expect_reg(OFS_INT_CONTROL, 32'h3, "flag set");
    expect_reg(OFS_RECEIVE_DATA, 32'ha5, "data");
    expect_reg(OFS_INT_CONTROL, 32'h1, "flag clear");
    $display("test single done");
  endtask : test_single
  task automatic test_overrun_single;
    master_setup();
    for (int i = 1; i <= 3; i++) begin
      char_in <= 9'(8'h11 * i);
      wr(RX, 8'ha0);
      wait_bit(BIT_SINGLE_RX, 1'b0);
      repeat (30) @(posedge clk);
    end
    expect_reg(RX, 32'h82, "overrun set");
    expect_reg(OFS_RECEIVE_DATA, 32'h11, "oldest kept");
    expect_reg(RX, 32'h80, "overrun cleared by read");
    expect_reg(OFS_INT_CONTROL, 32'h3, "one left");
    expect_reg(OFS_RECEIVE_DATA, 32'h22, "second kept");
    $display("test overrun single done");
  endtask : test_overrun_single
  task automatic test_continuous;
    int n;
    master_setup();
    char_in <= 9'h05a;
    wr(RX, 8'hb0);
    wait_bit(BIT_SINGLE_RX, 1'b0);
    expect_reg(RX, 32'h90, "continuous kept");
    wait_bit(BIT_OVERRUN, 1'b1);
    check(edges >= 24, 1'b1, "clock kept running");
    expect_reg(OFS_RECEIVE_DATA, 32'h5a, "readable in overrun");
    repeat (200) @(posedge clk);
    expect_reg(RX, 32'h92, "overrun held");
    wr(RX, 8'h80);
    expect_reg(RX, 32'h80, "overrun cleared");
    expect_reg(OFS_RECEIVE_DATA, 32'h5a, "second kept");
    expect_reg(OFS_INT_CONTROL, 32'h1, "none taken in overrun");
    repeat (30) @(posedge clk);
    edges = 0;
    wr(RX, 8'h90);
    n = 0;
    while (edges < 4 && n < 200) begin
      @(posedge clk);
      n++;
    end
    wr(RX, 8'h80);
    n = edges;
    repeat (30) @(posedge clk);
    check(edges, n, "clock stopped");
    check(ck_o, 1'b0, "clock idle");
    expect_reg(OFS_INT_CONTROL, 32'h1, "partial dropped");
    $display("test continuous done");
  endtask : test_continuous
  task automatic test_nine;
    master_setup();
    nbits <= 4'h9;
    char_in <= 9'h1c3;
    wr(RX, 8'he0);
    wait_bit(BIT_SINGLE_RX, 1'b0);
    repeat (40) @(posedge clk);
    check(edges, 9, "nine clocks");
    expect_reg(RX, 32'hc1, "ninth bit");
    expect_reg(OFS_RECEIVE_DATA, 32'hc3, "low byte");
    nbits <= 4'h8;
    $display("test nine done");
  endtask : test_nine
  task automatic test_slave;
    wr(OFS_TX_STATUS_CONTROL, 8'h10);
    wr(RX, 8'h90);
    check(ck_oe, 1'b0, "slave drives no clock");
    u_partner.slave_send(9'h03c, 8);
    u_partner.slave_send(9'h0c3, 8);
    repeat (10) @(posedge clk);
    expect_reg(OFS_RECEIVE_DATA, 32'h3c, "slave char");
    wr(RX, 8'h00);
    expect_reg(RX, 32'h0, "port reset");
    expect_reg(OFS_INT_CONTROL, 32'h1, "fifo emptied");
    check(irq, 1'b0, "irq cleared");
    $display("test slave done");
  endtask : test_slave
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  // all scenarios need some 1500 cycles; the ceiling leaves margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    char_in = 9'h000;
    nbits = 4'h8;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    test_reset();
    test_single();
    test_overrun_single();
    test_continuous();
    test_nine();
    test_slave();
    complete_run();
  end
endmodule : sync_serial_receiver_test
